// File: src/icg_clock_gen.sv
// clock generator: source select, reference and bus dividers, mode control, apb registers
//
// Function
// - select 00 fll, 01 internal, 10 external
// - reserved select 11 acts as fll
// - reference divider divides by two to field
// - reference select: 1 internal, 0 external
// - internal reference output follows its enable
// - stop keep-bit keeps internal reference running if its output is enabled or it was in use before stop
// - bus clock is half generator output
// - bus divider ratios 1, 2, 4, 8
// - debug clock is oscillator divided by two
// - reset starts in engaged internal mode
// - engaged internal: fll output, fll debug
// - engaged external: fll output, fll debug
// - bypassed internal: fll on, internal output
// - bypassed internal lowpower: fll off, no debug
// - bypassed external: fll on, external output
// - bypassed external lowpower: fll off, no debug
// - stop: no system or debug clock
// - nine trim bits adjust internal reference
// - drive oscillator control outputs
// - bus divider reset value divides by two
// - low-power bit disables fll in bypass modes unless debug
// - larger trim gives longer reference period
`timescale 1ns/10ps
module icg_clock_gen #(
    parameter int ref_div_w = 3,  // reference divider code width
    parameter int bus_div_w = 2   // bus divider code width
) (
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [11:0] paddr,
    input  wire  logic [31:0] pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire  logic        int_ref_clk_in,    // internal reference, async
    input  wire  logic        ext_ref_clk_in,    // external reference, async
    input  wire  logic        dco_clk_in,        // controlled_oscillator output, async
    input  wire  logic        osc_ready_in,      // crystal_osc_block started, async
    output logic              clock_gen_output,  // selected source after bus divider
    output logic              bus_clk_en,        // one-cycle pulse at half output rate
    output logic              background_debug_clock,
    output logic              int_ref_clock_out,
    output logic              ext_ref_clock_out,
    output logic              fll_enable,
    output logic              fll_ref_clk,       // divided fll reference
    output logic [8:0]        int_ref_trim,      // nine trim bits to the oscillator
    output logic              int_ref_run,
    output logic              osc_high_gain,
    output logic              osc_range,
    output logic              ext_ref_select,
    output logic              ext_ref_out_enable,
    output logic              ext_ref_stop_keep
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] ctrl_one_q;   // clock_ctrl_one
    logic [7:0] ctrl_two_q;   // clock_ctrl_two
    logic [7:0] trim_q;       // int_ref_trim_reg
    logic       fine_trim_bit_q;      // fine trim in status register
    logic       stop_q;       // stop request from power control
    logic       dbg_q;        // background_debug_active
    logic       ir_prev_q;    // internal-referenced mode before stop
    icg_pkg::icg_mode_e mode_q;  // current mode

    // field views
    logic [1:0]           clk_sel;
    logic [1:0]           clk_eff;
    logic [ref_div_w-1:0] ref_div;
    logic [bus_div_w-1:0] bus_div;
    logic                 ref_int;
    logic                 lp;

    assign clk_sel = ctrl_one_q[icg_pkg::clk_sel_lsb +: 2];
    assign ref_div = ctrl_one_q[icg_pkg::ref_div_lsb +: ref_div_w];
    assign ref_int = ctrl_one_q[icg_pkg::ref_sel_bit];
    assign bus_div = ctrl_two_q[icg_pkg::bus_div_lsb +: bus_div_w];
    assign lp      = ctrl_two_q[icg_pkg::lp_bit];
    // reserved code behaves as the fll selection
    assign clk_eff = (clk_sel == icg_pkg::sel_rsv) ? icg_pkg::sel_fll : clk_sel;

    // ************************************************************
    // apb slave: zero wait states, error on unmapped address
    // ************************************************************
    logic wr_en;
    logic rd_en;
    logic mapped;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign mapped = (paddr == icg_pkg::ctrl_one_off) || (paddr == icg_pkg::ctrl_two_off) ||
                    (paddr == icg_pkg::trim_off) || (paddr == icg_pkg::status_off) ||
                    (paddr == icg_pkg::mode_ctrl_off) || (paddr == icg_pkg::mode_status_off);

    // control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_q <= icg_pkg::ctrl_one_rst;
            ctrl_two_q <= icg_pkg::ctrl_two_rst;
        end else if (wr_en) begin
            if (paddr == icg_pkg::ctrl_one_off) begin
                ctrl_one_q <= pwdata[7:0];
            end
            if (paddr == icg_pkg::ctrl_two_off) begin
                ctrl_two_q <= pwdata[7:0];
            end
        end
    end

    // trim: eight coarse bits, one fine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q  <= icg_pkg::trim_rst;
            fine_trim_bit_q <= icg_pkg::fine_trim_bit_rst;
        end else if (wr_en) begin
            if (paddr == icg_pkg::trim_off) begin
                trim_q <= pwdata[7:0];
            end
            if (paddr == icg_pkg::status_off) begin
                fine_trim_bit_q <= pwdata[icg_pkg::fine_trim_bit_bit];  // only writable status bit
            end
        end
    end

    // stop request and debug-active flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
            dbg_q  <= 1'b0;
        end else if (wr_en && paddr == icg_pkg::mode_ctrl_off) begin
            stop_q <= pwdata[icg_pkg::stop_req_bit];
            dbg_q  <= pwdata[icg_pkg::dbg_act_bit];
        end
    end

    // ************************************************************
    // synchronisers for asynchronous inputs
    // ************************************************************
    logic [3:0] async_in;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    assign async_in = {osc_ready_in, dco_clk_in, ext_ref_clk_in, int_ref_clk_in};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            // two flops each; only the second is read by logic
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    logic ir_s, er_s, dco_s, osc_rdy_s;
    assign ir_s      = sync2_q[0];
    assign er_s      = sync2_q[1];
    assign dco_s     = sync2_q[2];
    assign osc_rdy_s = sync2_q[3];

    // ************************************************************
    // mode derivation
    // ************************************************************
    icg_pkg::icg_mode_e mode_d;
    always_comb begin
        if (stop_q) begin
            mode_d = icg_pkg::stop_mode;
        end else begin
            unique case (clk_eff)
                icg_pkg::sel_int: mode_d = (lp && !dbg_q) ?
                    icg_pkg::bypassed_internal_lowpower_mode : icg_pkg::bypassed_internal_mode;
                icg_pkg::sel_ext: mode_d = (lp && !dbg_q) ?
                    icg_pkg::bypassed_external_lowpower_mode : icg_pkg::bypassed_external_mode;
                default: mode_d = ref_int ?
                    icg_pkg::engaged_internal_mode : icg_pkg::engaged_external_mode;
            endcase
        end
    end

    // registered mode; notes internal reference before stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= icg_pkg::engaged_internal_mode;
            ir_prev_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            if (mode_q != icg_pkg::stop_mode) begin
                // any internally referenced mode
                ir_prev_q <= (mode_q == icg_pkg::engaged_internal_mode) ||
                             (mode_q == icg_pkg::bypassed_internal_mode) ||
                             (mode_q == icg_pkg::bypassed_internal_lowpower_mode);
            end
        end
    end

    // ************************************************************
    // fll reference divider: 2**code, from synchronised reference edges
    // ************************************************************
    logic       ref_src;
    logic       ref_src_q;
    logic [6:0] ref_cnt_q;
    logic       ref_out_q;
    assign ref_src = ref_int ? ir_s : er_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_src_q <= 1'b0;
            ref_cnt_q <= 7'h00;
            ref_out_q <= 1'b0;
        end else begin
            ref_src_q <= ref_src;
            if (ref_div == '0) begin
                ref_out_q <= ref_src;  // divide by 1 passes through
                ref_cnt_q <= 7'h00;
            end else if (ref_src && !ref_src_q) begin
                // toggle every 2**(code-1) rising edges: divide by 2**code
                if (ref_cnt_q >= (7'h01 << (ref_div - 1'b1)) - 7'h01) begin
                    ref_cnt_q <= 7'h00;
                    ref_out_q <= !ref_out_q;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 7'h01;
                end
            end
        end
    end

    // ************************************************************
    // source selection and bus divider; switching on divider wrap, or while source low at divide by 1
    // ************************************************************
    logic       fll_on;
    logic       src_clk;
    logic [1:0] src_sel_q;
    logic [3:0] bus_cnt_q;
    logic       out_q;
    logic       dco_q;
    logic       src_q;
    assign fll_on = (mode_q == icg_pkg::engaged_internal_mode) ||
                    (mode_q == icg_pkg::engaged_external_mode) ||
                    (mode_q == icg_pkg::bypassed_internal_mode) ||
                    (mode_q == icg_pkg::bypassed_external_mode);
    always_comb begin
        unique case (src_sel_q)
            icg_pkg::sel_int: src_clk = ir_s;
            icg_pkg::sel_ext: src_clk = er_s;
            default:          src_clk = dco_s;
        endcase
    end

    // bus divider counts source edges; output toggles at 2**(code-1)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_q <= icg_pkg::sel_fll;
            bus_cnt_q <= 4'h0;
            out_q     <= 1'b0;
            dco_q     <= 1'b0;
            src_q     <= 1'b0;
        end else begin
            dco_q <= dco_s;
            src_q <= src_clk;
            if (mode_q == icg_pkg::stop_mode) begin
                out_q     <= 1'b0;
                bus_cnt_q <= 4'h0;
            end else if (bus_div == '0) begin
                out_q <= src_clk;
                // switch while low: no runt pulse
                if (!src_clk) begin
                    src_sel_q <= clk_eff;
                end
            end else begin
                // count rising source edges, wrap at the ratio
                if (src_clk && !src_q) begin
                    bus_cnt_q <= (bus_cnt_q >= (4'h1 << bus_div) - 4'h1) ? 4'h0 : bus_cnt_q + 4'h1;
                end
                out_q <= (bus_cnt_q < (4'h1 << (bus_div - 1'b1)));
                if (bus_cnt_q == 4'h0 && !out_q) begin
                    src_sel_q <= clk_eff;
                end
            end
        end
    end

    // bus enable pulse, debug clock halves dco
    logic bus_ph_q;
    logic out_prev_q;
    logic bdc_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_ph_q   <= 1'b0;
            out_prev_q <= 1'b0;
            bdc_q      <= 1'b0;
            bus_clk_en <= 1'b0;
        end else begin
            out_prev_q <= out_q;
            bus_clk_en <= 1'b0;
            if (out_q && !out_prev_q) begin
                bus_ph_q   <= !bus_ph_q;
                bus_clk_en <= bus_ph_q;
            end
            if (!fll_on) begin
                bdc_q <= 1'b0;
            end else if (dco_s && !dco_q) begin
                bdc_q <= !bdc_q;
            end
        end
    end

    // ************************************************************
    // registered outputs
    // ************************************************************
    logic ir_run_d;
    always_comb begin
        if (mode_q == icg_pkg::stop_mode) begin
            ir_run_d = ctrl_one_q[icg_pkg::ir_keep_bit] &&
                       (ctrl_one_q[icg_pkg::ir_oen_bit] || ir_prev_q);
        end else begin
            ir_run_d = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_gen_output       <= 1'b0;
            background_debug_clock <= 1'b0;
            int_ref_clock_out      <= 1'b0;
            ext_ref_clock_out      <= 1'b0;
            fll_enable             <= 1'b0;
            fll_ref_clk            <= 1'b0;
            int_ref_trim           <= 9'h000;
            int_ref_run            <= 1'b0;
            osc_high_gain          <= 1'b0;
            osc_range              <= 1'b0;
            ext_ref_select         <= 1'b0;
            ext_ref_out_enable     <= 1'b0;
            ext_ref_stop_keep      <= 1'b0;
        end else begin
            clock_gen_output       <= out_q;
            background_debug_clock <= bdc_q;
            // gated by enable and run
            int_ref_clock_out      <= ctrl_one_q[icg_pkg::ir_oen_bit] && ir_run_d && ir_s;
            ext_ref_clock_out      <= ctrl_two_q[icg_pkg::er_oen_bit] && er_s;
            fll_enable             <= fll_on;
            fll_ref_clk            <= fll_on && ref_out_q;
            int_ref_trim           <= {trim_q, fine_trim_bit_q};
            int_ref_run            <= ir_run_d;
            osc_high_gain          <= ctrl_two_q[icg_pkg::hgo_bit];
            osc_range              <= ctrl_two_q[icg_pkg::range_bit];
            ext_ref_select         <= ctrl_two_q[icg_pkg::er_sel_bit];
            ext_ref_out_enable     <= ctrl_two_q[icg_pkg::er_oen_bit];
            ext_ref_stop_keep      <= ctrl_two_q[icg_pkg::er_keep_bit];
        end
    end

    // ************************************************************
    // apb read data and answer
    // ************************************************************
    logic [7:0] rd_d;
    always_comb begin
        rd_d = 8'h00;
        unique case (paddr)
            icg_pkg::ctrl_one_off: rd_d = ctrl_one_q;
            icg_pkg::ctrl_two_off: rd_d = ctrl_two_q;
            icg_pkg::trim_off:     rd_d = trim_q;
            icg_pkg::status_off: begin
                rd_d[icg_pkg::ir_stat_bit]       = ref_int;
                rd_d[icg_pkg::clk_stat_lsb +: 2] = src_sel_q;
                rd_d[icg_pkg::osc_rdy_bit]       = osc_rdy_s;
                rd_d[icg_pkg::fine_trim_bit_bit]         = fine_trim_bit_q;
            end
            icg_pkg::mode_ctrl_off: rd_d = {6'h00, dbg_q, stop_q};
            icg_pkg::mode_status_off: rd_d = {5'h00, mode_q};
            default: rd_d = 8'h00;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // registered in setup phase so access phase sees it at once
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_d} : 32'h0000_0000;
        end
    end
endmodule : icg_clock_gen

// File: src/icg_pkg.sv
// package: register map, field layout, reset values and modes of the clock generator
package icg_pkg;
    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [11:0] ctrl_one_off    = 12'h000;  // clock_ctrl_one
    localparam logic [11:0] ctrl_two_off    = 12'h004;  // clock_ctrl_two
    localparam logic [11:0] trim_off        = 12'h008;  // int_ref_trim_reg
    localparam logic [11:0] status_off      = 12'h00c;  // clock_status_ctrl
    localparam logic [11:0] mode_ctrl_off   = 12'h010;  // stop request, debug active
    localparam logic [11:0] mode_status_off = 12'h014;  // current mode
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int clk_sel_lsb    = 6;  // clk_source_sel [7:6]
    localparam int ref_div_lsb    = 3;  // fll_ref_divider [5:3]
    localparam int ref_sel_bit    = 2;  // fll_ref_select
    localparam int ir_oen_bit     = 1;  // int_ref_out_enable
    localparam int ir_keep_bit    = 0;  // int_ref_stop_keep
    localparam int bus_div_lsb    = 6;  // bus_divider [7:6]
    localparam int range_bit      = 5;  // oscillator frequency range
    localparam int hgo_bit        = 4;  // osc_high_gain
    localparam int lp_bit         = 3;  // fll_off_in_bypass
    localparam int er_sel_bit     = 2;  // ext_ref_select
    localparam int er_oen_bit     = 1;  // ext_ref_out_enable
    localparam int er_keep_bit    = 0;  // ext_ref_stop_keep
    localparam int ir_stat_bit    = 4;  // int_ref_status
    localparam int clk_stat_lsb   = 2;  // clk_source_status [3:2]
    localparam int osc_rdy_bit    = 1;  // osc_ready_flag
    localparam int fine_trim_bit_bit      = 0;  // fine_trim_bit
    localparam int stop_req_bit   = 0;  // mode control: enter stop
    localparam int dbg_act_bit    = 1;  // mode control: debug active
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] ctrl_one_rst = 8'h04;  // fll, div 1, internal reference
    localparam logic [7:0] ctrl_two_rst = 8'h40;  // bus divide by 2
    localparam logic [7:0] trim_rst     = 8'h80;  // mid-scale trim
    localparam logic       fine_trim_bit_rst    = 1'b0;
    // ************************************************************
    // clock source codes and modes
    // ************************************************************
    localparam logic [1:0] sel_fll = 2'h0;
    localparam logic [1:0] sel_int = 2'h1;
    localparam logic [1:0] sel_ext = 2'h2;
    localparam logic [1:0] sel_rsv = 2'h3;
    typedef enum logic [2:0] {
        engaged_internal_mode,
        engaged_external_mode,
        bypassed_internal_mode,
        bypassed_internal_lowpower_mode,
        bypassed_external_mode,
        bypassed_external_lowpower_mode,
        stop_mode
    } icg_mode_e;
endpackage : icg_pkg

// File: dv/icg_monitor.sv
// checker: port-level relations of the clock generator
`timescale 1ns/10ps
module icg_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       bus_clk_en,
    input wire logic       background_debug_clock,
    input wire logic       int_ref_clock_out,
    input wire logic       ext_ref_clock_out,
    input wire logic       fll_enable,
    input wire logic       fll_ref_clk,
    input wire logic       int_ref_run,
    input wire logic [8:0] int_ref_trim,
    input wire logic       osc_high_gain,
    input wire logic       ext_ref_select,
    input wire logic       ext_ref_out_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic take_w = psel && penable && pwrite;
    // gated outputs quiet after enable low
    property p_bdc_off; !fll_enable [*3] |-> !background_debug_clock; endproperty
    a_bdc_off: assert property (p_bdc_off) else $error("debug clock, loop off");
    property p_ref_off; !fll_enable [*3] |-> !fll_ref_clk; endproperty
    a_ref_off: assert property (p_ref_off) else $error("loop ref, loop off");
    property p_ir_off; !int_ref_run [*3] |-> !int_ref_clock_out; endproperty
    a_ir_off: assert property (p_ir_off) else $error("int ref out, halted");
    property p_er_off; !ext_ref_out_enable [*3] |-> !ext_ref_clock_out; endproperty
    a_er_off: assert property (p_er_off) else $error("ext ref out, disabled");
    // bus pulse lasts one cycle
    property p_bus; bus_clk_en |=> !bus_clk_en; endproperty
    a_bus: assert property (p_bus) else $error("bus enable held");
    // outputs move only after a write
    property p_osc; $past(presetn, 2) && $changed({osc_high_gain, ext_ref_select})
        |-> $past(take_w) || $past(take_w, 2); endproperty
    a_osc: assert property (p_osc) else $error("osc control moved");
    property p_trim; $past(presetn, 2) && $changed(int_ref_trim)
        |-> $past(take_w) || $past(take_w, 2); endproperty
    a_trim: assert property (p_trim) else $error("trim moved");
    property p_fll; $past(presetn, 3) && $changed(fll_enable)
        |-> $past(take_w) || $past(take_w, 2) || $past(take_w, 3); endproperty
    a_fll: assert property (p_fll) else $error("loop enable moved");
    c_bus: cover property (bus_clk_en);
    c_off: cover property (!fll_enable);
    c_ir: cover property (int_ref_clock_out);
endmodule : icg_monitor

bind icg_clock_gen icg_monitor u_icg_monitor (.*);

// File: dv/icg_far_model.sv
// far-side model: reference clocks, controlled oscillator and crystal start-up
`timescale 1ns/10ps
module icg_far_model #(
    parameter int ir_half  = 200,  // int ref half period, ns
    parameter int er_half  = 260,  // ext ref half period, ns
    parameter int dco_half = 40    // dco half period, ns
) (
    output logic int_ref_clk_in,
    output logic ext_ref_clk_in,
    output logic dco_clk_in,
    output logic osc_ready_in
);
    // free-running sources: references below 5 MHz, dco at 12.5 MHz
    initial begin
        {int_ref_clk_in, ext_ref_clk_in, dco_clk_in, osc_ready_in} = '0;
        fork
            forever #(ir_half) int_ref_clk_in = ~int_ref_clk_in;
            forever #(er_half) ext_ref_clk_in = ~ext_ref_clk_in;
            forever #(dco_half) dco_clk_in = ~dco_clk_in;
            #100 osc_ready_in = 1'b1;
        join
    end
endmodule : icg_far_model

// File: dv/testbench.sv
// testbench: apb-driven scenarios for the clock generator
`timescale 1ns/10ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, clock_gen_output, bus_clk_en, background_debug_clock;
    logic        int_ref_clock_out, ext_ref_clock_out, fll_enable, fll_ref_clk, int_ref_run;
    logic        osc_high_gain, osc_range, ext_ref_select, ext_ref_out_enable, ext_ref_stop_keep;
    logic        int_ref_clk_in, ext_ref_clk_in, dco_clk_in, osc_ready_in;
    logic [8:0]  int_ref_trim;
    int          bad_count, checks, cnt[5];
    icg_clock_gen u_icg_clock_gen (.*);
    icg_far_model u_icg_far_model (.*);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // x never passes
    task automatic chk(input logic [31:0] got, exp, tol);
        checks++;
        if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
            bad_count++;
            $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rdat, x, 32'h0);
    endtask : rd
    // count output rises over 3200 cycles
    task automatic meas;
        logic [4:0] p = 5'h0, s;
        repeat (600) @(posedge pclk);
        cnt = '{default: 0};
        repeat (3200) begin
            @(posedge pclk);
            s = {fll_ref_clk, int_ref_clock_out, background_debug_clock, bus_clk_en,
                 clock_gen_output};
            for (int i = 0; i < 5; i++) cnt[i] += (s[i] && !p[i]);
            p = s;
        end
    endtask : meas
    task automatic t_reset;
        rd(icg_pkg::ctrl_one_off, 32'h04);
        rd(icg_pkg::ctrl_two_off, 32'h40);
        rd(icg_pkg::mode_status_off, 32'h0);
        rd(icg_pkg::status_off, 32'h12);
        chk(fll_enable, 32'h1, 32'h0);
        chk(int_ref_trim, 32'h100, 32'h0);
        apb(1'b1, icg_pkg::trim_off, 32'h01);
        apb(1'b1, icg_pkg::status_off, 32'h01);
        chk(int_ref_trim, 32'h003, 32'h0);
    endtask : t_reset
    // each mode in turn, reserved select last
    task automatic t_modes;
        logic [7:0] c1[7] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80, 8'hc4};
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, icg_pkg::ctrl_two_off, (i == 3 || i == 5) ? 32'h48 : 32'h40);
            apb(1'b1, icg_pkg::ctrl_one_off, {24'h0, c1[i]});
            rd(icg_pkg::mode_status_off, (i == 6) ? 0 : i);
        end
        repeat (200) @(posedge pclk);
        rd(icg_pkg::status_off, 32'h13);
        apb(1'b1, icg_pkg::mode_ctrl_off, 32'h1);
        rd(icg_pkg::mode_status_off, 32'h6);
        chk(fll_enable, 32'h0, 32'h0);
        apb(1'b1, icg_pkg::mode_ctrl_off, 32'h0);
        apb(1'b1, icg_pkg::ctrl_two_off, 32'h48);
        apb(1'b1, icg_pkg::ctrl_one_off, 32'h44);
        chk(fll_enable, 32'h0, 32'h0);
        apb(1'b1, icg_pkg::mode_ctrl_off, 32'h2);
        chk(fll_enable, 32'h1, 32'h0);
        apb(1'b1, icg_pkg::mode_ctrl_off, 32'h0);
        apb(1'b1, icg_pkg::ctrl_two_off, 32'h37);
        chk({osc_range, osc_high_gain, ext_ref_select, ext_ref_out_enable, ext_ref_stop_keep},
            32'h1f, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(rerr, 32'h1, 32'h0);
        chk(rdat, 32'h0, 32'h0);
    endtask : t_modes
    // internal source: 80 rises per window
    task automatic t_clocks;
        apb(1'b1, icg_pkg::ctrl_one_off, 32'h44);
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, icg_pkg::ctrl_two_off, b << 6);
            meas;
            chk(cnt[0], 80 >> b, 32'h2);
            chk(cnt[1], 40 >> b, 32'h2);
            chk(cnt[2], 32'd200, 32'h2);
        end
        apb(1'b1, icg_pkg::ctrl_two_off, 32'h08);
        meas;
        chk(cnt[2] + cnt[4], 32'h0, 32'h0);
        apb(1'b1, icg_pkg::ctrl_one_off, 32'h80);
        meas;
        chk(cnt[0], 32'd61, 32'h2);
        chk(cnt[2], 32'h0, 32'h0);
        apb(1'b1, icg_pkg::ctrl_two_off, 32'h40);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, icg_pkg::ctrl_one_off, 32'h04 | (k << 3));
            meas;
            chk(cnt[4], 80 >> k, 32'h2);
        end
        apb(1'b1, icg_pkg::ctrl_one_off, 32'h00);
        meas;
        chk(cnt[4], 32'd61, 32'h2);
    endtask : t_clocks
    // int ref output, stop with keep set and clear
    task automatic t_stop;
        logic [7:0] c1[3] = '{8'h06, 8'h07, 8'h06};
        for (int j = 0; j < 3; j++) begin
            apb(1'b1, icg_pkg::ctrl_one_off, {24'h0, c1[j]});
            apb(1'b1, icg_pkg::mode_ctrl_off, (j > 0) ? 32'h1 : 32'h0);
            meas;
            chk(cnt[3], (j == 2) ? 0 : 80, 32'h2);
        end
        chk(cnt[0], 32'h0, 32'h0);
        apb(1'b1, icg_pkg::mode_ctrl_off, 32'h0);
    endtask : t_stop
    initial begin
        #800000;
        bad_count++;
        print_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, bad_count, checks} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_modes;
        t_clocks;
        t_stop;
        print_verdict;
    end
endmodule : testbench
